// file: rf_check_defines.svh
// Purpose: Constants for the register-file machine-check information word.
// Assumes: Included once per compilation unit through its guard.
// Notes: Field positions are bit indices within the 64-bit word.
`ifndef RF_CHECK_DEFINES_SVH
`define RF_CHECK_DEFINES_SVH

`define FILE_SEL_LSB 0
`define FILE_SEL_MSB 3
`define ACCESS_LSB 4
`define ACCESS_MSB 7
`define REG_NUM_LSB 8
`define REG_NUM_MSB 14
`define REG_NUM_VALID_BIT 15
`define RSVD_LO_LSB 16
`define RSVD_LO_MSB 53
`define SET_FLAG_BIT 54
`define SET_VALID_BIT 55
`define PRIV_LSB 56
`define PRIV_MSB 57
`define PRIV_VALID_BIT 58
`define CORRECTED_BIT 59
`define RSVD_HI_LSB 60
`define RSVD_HI_MSB 62
`define PRECISE_IP_BIT 63
`define FILE_SEL_MAX 4'hD
`define WORD_RESET 64'h0000_0000_0000_0000
`define FILE_SEL_RESET 4'h0
`define ACCESS_RESET 4'h0
`define REG_NUM_RESET 7'h00
`define PRIV_RESET 2'h0
`define FLAG_RESET 1'h0

`endif

// file: rf_check_pkg.sv
// Purpose: Types for the register-file machine-check information word.
// Assumes: Nothing beyond the defines header.
// Notes: Codes above the last named file are reserved.
package rf_check_pkg;

  typedef enum logic [3:0] {
    FILE_UNKNOWN = 4'h0,
    FILE_GEN_BANK1 = 4'h1,
    FILE_GEN_BANK0 = 4'h2,
    FILE_FLOAT = 4'h3,
    FILE_BRANCH = 4'h4,
    FILE_PREDICATE = 4'h5,
    FILE_APPLICATION = 4'h6,
    FILE_CONTROL = 4'h7,
    FILE_REGION = 4'h8,
    FILE_PROT_KEY = 4'h9,
    FILE_DATA_BKPT = 4'hA,
    FILE_INSTR_BKPT = 4'hB,
    FILE_MON_CTRL = 4'hC,
    FILE_MON_DATA = 4'hD
  } failing_file_t;

  typedef enum logic [3:0] {
    ACCESS_UNKNOWN = 4'h0,
    ACCESS_READ = 4'h1,
    ACCESS_WRITE = 4'h2
  } access_kind_t;

endpackage : rf_check_pkg

// file: rf_check_if.sv
// Purpose: Carries the captured error fields between capture and packing.
// Assumes: Single clock domain.
// Notes: Packer reads, top drives.
`timescale 1ns/1ps
interface rf_check_if;
  logic [3:0] failing_file_selector;
  logic [3:0] access_kind;
  logic [6:0] reg_num;
  logic reg_num_valid;
  logic instruction_set_flag;
  logic set_flag_valid;
  logic [1:0] privilege_level;
  logic privilege_valid;
  logic corrected;
  logic precise_ip_logged;
  modport src (output failing_file_selector, access_kind, reg_num, reg_num_valid,
               instruction_set_flag, set_flag_valid, privilege_level,
               privilege_valid, corrected, precise_ip_logged);
  modport dst (input failing_file_selector, access_kind, reg_num, reg_num_valid,
               instruction_set_flag, set_flag_valid, privilege_level,
               privilege_valid, corrected, precise_ip_logged);
endinterface : rf_check_if

// file: rf_check_pack.sv
// Purpose: Packs captured fields into the 64-bit information word.
// Assumes: Fields already qualified by their validity flags.
// Notes: Purely combinational.
`timescale 1ns/1ps
`include "rf_check_defines.svh"
module rf_check_pack (
  rf_check_if.dst fld,
  output logic [63:0] word
);
  always_comb begin
    word = `WORD_RESET;
    word[`FILE_SEL_MSB:`FILE_SEL_LSB] = fld.failing_file_selector;
    word[`ACCESS_MSB:`ACCESS_LSB] = fld.access_kind;
    word[`REG_NUM_MSB:`REG_NUM_LSB] = fld.reg_num;
    word[`REG_NUM_VALID_BIT] = fld.reg_num_valid;
    word[`SET_FLAG_BIT] = fld.instruction_set_flag;
    word[`SET_VALID_BIT] = fld.set_flag_valid;
    word[`PRIV_MSB:`PRIV_LSB] = fld.privilege_level;
    word[`PRIV_VALID_BIT] = fld.privilege_valid;
    word[`CORRECTED_BIT] = fld.corrected;
    word[`PRECISE_IP_BIT] = fld.precise_ip_logged;
  end
endmodule : rf_check_pack

// file: rf_check_word.sv
// Purpose: Captures a register-file machine-check event into an error word.
// Assumes: Event inputs come from logic on core_clk.
// Notes: Word updates two cycles after capture; invalid fields read zero.
`timescale 1ns/1ps
`include "rf_check_defines.svh"
module rf_check_word (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic capture,
  input wire rf_check_pkg::failing_file_t failing_file_selector,
  input wire rf_check_pkg::access_kind_t access_kind,
  input wire logic [6:0] reg_num,
  input wire logic reg_num_known,
  input wire logic instruction_set_flag,
  input wire logic set_flag_known,
  input wire logic [1:0] privilege_level,
  input wire logic privilege_known,
  input wire logic corrected,
  input wire logic precise_ip_logged,
  output logic [63:0] error_word,
  output logic word_valid
);
  import rf_check_pkg::*;

  // ------------------------------------------------------------
  // Stored fields and their next values
  // ------------------------------------------------------------
  rf_check_if fld ();
  logic [63:0] packed_word;
  logic [63:0] error_word_ff;
  logic [63:0] nxt_error_word;
  logic word_valid_ff;
  logic nxt_word_valid;
  logic [3:0] file_ff;
  logic [3:0] access_ff;
  logic [6:0] reg_ff;
  logic reg_v_ff;
  logic set_ff;
  logic set_v_ff;
  logic [1:0] priv_ff;
  logic priv_v_ff;
  logic corr_ff;
  logic pip_ff;
  logic [3:0] nxt_file;
  logic [3:0] nxt_access;
  logic [6:0] nxt_reg;
  logic nxt_reg_v;
  logic nxt_set;
  logic nxt_set_v;
  logic [1:0] nxt_priv;
  logic nxt_priv_v;
  logic nxt_corr;
  logic nxt_pip;
  logic announce_ff;
  logic nxt_announce;

  // ------------------------------------------------------------
  // Field helpers
  // ------------------------------------------------------------
  // Codes 14 and 15 are reserved; they are stored as unknown so that the
  // handler never meets a register file that it cannot name.
  function automatic logic [3:0] legal_file_code(input logic [3:0] code);
    logic [3:0] result;
    unique case (code)
      FILE_UNKNOWN,
      FILE_GEN_BANK1,
      FILE_GEN_BANK0,
      FILE_FLOAT,
      FILE_BRANCH,
      FILE_PREDICATE,
      FILE_APPLICATION,
      FILE_CONTROL,
      FILE_REGION,
      FILE_PROT_KEY,
      FILE_DATA_BKPT,
      FILE_INSTR_BKPT,
      FILE_MON_CTRL,
      FILE_MON_DATA: begin
        result = code;
      end
      default: begin
        result = FILE_UNKNOWN;
      end
    endcase
    return result;
  endfunction : legal_file_code

  // A field whose validity flag is low is stored as zero, so that no value
  // left over from an earlier check can show through it.
  function automatic logic [6:0] gate_field(input logic [6:0] value, input logic known);
    logic [6:0] result;
    if (known) begin
      result = value;
    end else begin
      result = 7'h00;
    end
    return result;
  endfunction : gate_field

  // ------------------------------------------------------------
  // Register file code
  // ------------------------------------------------------------
  always_comb begin
    nxt_file = file_ff;
    if (capture) begin
      nxt_file = legal_file_code(failing_file_selector);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      file_ff <= `FILE_SEL_RESET;
    end else begin
      file_ff <= nxt_file;
    end
  end

  // ------------------------------------------------------------
  // Access kind
  // ------------------------------------------------------------
  // Values above write pass through untouched, since their meaning belongs
  // to the processor and not to this block.
  always_comb begin
    nxt_access = access_ff;
    if (capture) begin
      nxt_access = access_kind;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      access_ff <= `ACCESS_RESET;
    end else begin
      access_ff <= nxt_access;
    end
  end

  // ------------------------------------------------------------
  // Register number
  // ------------------------------------------------------------
  // The number and its validity flag load on the same edge, so the handler
  // never sees one of them from an older check.
  always_comb begin
    nxt_reg = reg_ff;
    nxt_reg_v = reg_v_ff;
    if (capture) begin
      nxt_reg_v = reg_num_known;
      nxt_reg = gate_field(reg_num, reg_num_known);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_ff <= `REG_NUM_RESET;
      reg_v_ff <= `FLAG_RESET;
    end else begin
      reg_ff <= nxt_reg;
      reg_v_ff <= nxt_reg_v;
    end
  end

  // ------------------------------------------------------------
  // Instruction set
  // ------------------------------------------------------------
  // An unknown instruction set reads as native, which the low validity bit
  // tells the handler to ignore.
  always_comb begin
    nxt_set = set_ff;
    nxt_set_v = set_v_ff;
    if (capture) begin
      nxt_set_v = set_flag_known;
      nxt_set = 1'(gate_field({6'h00, instruction_set_flag}, set_flag_known));
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      set_ff <= `FLAG_RESET;
      set_v_ff <= `FLAG_RESET;
    end else begin
      set_ff <= nxt_set;
      set_v_ff <= nxt_set_v;
    end
  end

  // ------------------------------------------------------------
  // Privilege level
  // ------------------------------------------------------------
  // An unknown privilege reads as level zero, which the low validity bit
  // tells the handler to ignore.
  always_comb begin
    nxt_priv = priv_ff;
    nxt_priv_v = priv_v_ff;
    if (capture) begin
      nxt_priv_v = privilege_known;
      nxt_priv = 2'(gate_field({5'h00, privilege_level}, privilege_known));
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      priv_ff <= `PRIV_RESET;
      priv_v_ff <= `FLAG_RESET;
    end else begin
      priv_ff <= nxt_priv;
      priv_v_ff <= nxt_priv_v;
    end
  end

  // ------------------------------------------------------------
  // Check status
  // ------------------------------------------------------------
  // Neither status flag has a validity bit; each is passed on as given.
  always_comb begin
    nxt_corr = corr_ff;
    nxt_pip = pip_ff;
    if (capture) begin
      nxt_corr = corrected;
      nxt_pip = precise_ip_logged;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      corr_ff <= `FLAG_RESET;
      pip_ff <= `FLAG_RESET;
    end else begin
      corr_ff <= nxt_corr;
      pip_ff <= nxt_pip;
    end
  end

  // ------------------------------------------------------------
  // Capture announce
  // ------------------------------------------------------------
  // The word register loads one edge after the fields, so the announce is
  // delayed by that edge to let word_valid rise together with the word.
  always_comb begin
    nxt_announce = capture;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      announce_ff <= `FLAG_RESET;
    end else begin
      announce_ff <= nxt_announce;
    end
  end

  // ------------------------------------------------------------
  // Field carrier
  // ------------------------------------------------------------
  // The packer reads only the stored fields, never the live inputs, so one
  // word always describes one check.
  assign fld.failing_file_selector = file_ff;
  assign fld.access_kind = access_ff;
  assign fld.reg_num = reg_ff;
  assign fld.reg_num_valid = reg_v_ff;
  assign fld.instruction_set_flag = set_ff;
  assign fld.set_flag_valid = set_v_ff;
  assign fld.privilege_level = priv_ff;
  assign fld.privilege_valid = priv_v_ff;
  assign fld.corrected = corr_ff;
  assign fld.precise_ip_logged = pip_ff;

  // ------------------------------------------------------------
  // Word packing
  // ------------------------------------------------------------
  rf_check_pack u_pack (
    .fld(fld),
    .word(packed_word)
  );

  // ------------------------------------------------------------
  // Output word register
  // ------------------------------------------------------------
  // The word reloads only on an announce, so it stands unchanged between
  // checks and word_valid never runs ahead of it.
  always_comb begin
    nxt_error_word = error_word_ff;
    if (announce_ff) begin
      nxt_error_word = packed_word;
    end
    nxt_word_valid = word_valid_ff | announce_ff;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      error_word_ff <= `WORD_RESET;
      word_valid_ff <= `FLAG_RESET;
    end else begin
      error_word_ff <= nxt_error_word;
      word_valid_ff <= nxt_word_valid;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign error_word = error_word_ff;
  assign word_valid = word_valid_ff;

endmodule : rf_check_word

// file: rf_check_word_properties.sv
// Purpose: Concurrent checks on the error word ports.
// Assumes: One clock, synchronous reset.
// Notes: Word lands two edges after capture.
`timescale 1ns/1ps
module rf_check_word_properties (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic capture,
  input wire rf_check_pkg::failing_file_t failing_file_selector,
  input wire rf_check_pkg::access_kind_t access_kind,
  input wire logic [6:0] reg_num,
  input wire logic reg_num_known,
  input wire logic instruction_set_flag,
  input wire logic set_flag_known,
  input wire logic [1:0] privilege_level,
  input wire logic privilege_known,
  input wire logic corrected,
  input wire logic precise_ip_logged,
  input wire logic [63:0] error_word,
  input wire logic word_valid
);
  import rf_check_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_file;
    $past(capture, 2) |-> error_word[3:0] ==
      ($past(failing_file_selector, 2) > 4'hD ? 4'h0 : $past(failing_file_selector, 2));
  endproperty
  property p_access;
    $past(capture, 2) |-> error_word[7:4] == $past(access_kind, 2);
  endproperty
  property p_reg;
    $past(capture, 2) |-> error_word[15:8] ==
      ($past(reg_num_known, 2) ? {1'b1, $past(reg_num, 2)} : 8'h00);
  endproperty
  property p_set;
    $past(capture, 2) |-> error_word[55:54] ==
      {$past(set_flag_known, 2), $past(set_flag_known, 2) & $past(instruction_set_flag, 2)};
  endproperty
  property p_priv;
    $past(capture, 2) |-> error_word[58:56] ==
      {$past(privilege_known, 2), $past(privilege_known, 2) ? $past(privilege_level, 2) : 2'h0};
  endproperty
  property p_corr;
    $past(capture, 2) |-> error_word[59] == $past(corrected, 2);
  endproperty
  property p_pip;
    $past(capture, 2) |-> error_word[63] == $past(precise_ip_logged, 2);
  endproperty
  property p_rsvd;
    error_word[62:60] == 3'h0 && error_word[53:16] == 38'h0;
  endproperty
  a_file: assert property (p_file) else $error("file code wrong");
  a_access: assert property (p_access) else $error("access kind wrong");
  a_reg: assert property (p_reg) else $error("register number wrong");
  a_set: assert property (p_set) else $error("set flag wrong");
  a_priv: assert property (p_priv) else $error("privilege wrong");
  a_corr: assert property (p_corr) else $error("corrected bit wrong");
  a_pip: assert property (p_pip) else $error("precise ip bit wrong");
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  c_cap: cover property (capture);
  c_b2b: cover property (capture ##1 capture);
  c_valid: cover property ($rose(word_valid));
endmodule : rf_check_word_properties

bind rf_check_word rf_check_word_properties u_props (.core_clk, .sys_rst, .capture,
  .failing_file_selector, .access_kind, .reg_num, .reg_num_known, .instruction_set_flag,
  .set_flag_known, .privilege_level, .privilege_known, .corrected, .precise_ip_logged,
  .error_word, .word_valid);

// file: rf_check_reader.sv
// Purpose: Handler model that reads the word once it is announced.
// Assumes: Announce pulse is the capture strobe.
// Notes: Reads two edges after the announce.
`timescale 1ns/1ps
module fw_reader (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic notify,
  input wire logic [63:0] error_word,
  output logic rd_valid,
  output logic [63:0] rd_word
);
  logic [1:0] pend_ff;
  always_ff @(posedge core_clk) begin
    pend_ff <= sys_rst ? 2'h0 : {pend_ff[0], notify};
  end
  assign rd_valid = pend_ff[1];
  assign rd_word = error_word;
endmodule : fw_reader

// file: rf_check_word_tb.sv
// Purpose: Self-checking bench for the error word.
// Assumes: 25 MHz clock.
// Notes: Stimulus word bits map onto the event inputs.
`timescale 1ns/1ps
module rf_check_word_tb;
  import rf_check_pkg::*;
  logic core_clk, sys_rst, capture, valid, rd_valid;
  logic [31:0] stim;
  logic [63:0] word, rd_word;
  logic [63:0] exp_q[$];
  integer seed = 32'h8D9E5417;
  int error_cnt = 0;
  int samples_checked = 0;
  rf_check_word u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .capture(capture),
    .failing_file_selector(failing_file_t'(stim[3:0])), .access_kind(access_kind_t'(stim[7:4])),
    .reg_num(stim[14:8]), .reg_num_known(stim[15]), .instruction_set_flag(stim[16]),
    .set_flag_known(stim[17]), .privilege_level(stim[19:18]), .privilege_known(stim[20]),
    .corrected(stim[21]), .precise_ip_logged(stim[22]), .error_word(word), .word_valid(valid));
  fw_reader u_fw (.core_clk(core_clk), .sys_rst(sys_rst), .notify(capture),
    .error_word(word), .rd_valid(rd_valid), .rd_word(rd_word));
  always #20 core_clk = ~core_clk;
  function automatic logic [63:0] expect_word(input logic [31:0] v);
    return {v[22], 3'h0, v[21], v[20], v[20] ? v[19:18] : 2'h0, v[17], v[17] & v[16], 38'h0,
      v[15], v[15] ? v[14:8] : 7'h0, v[7:4], v[3:0] > 4'hD ? 4'h0 : v[3:0]};
  endfunction : expect_word
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic cap(input logic [31:0] v, input logic c);
    @(posedge core_clk);
    #1 stim = v;
    capture = c;
    if (c) exp_q.push_back(expect_word(v));
  endtask : cap
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  always @(negedge core_clk) begin
    if (rd_valid) begin
      check("error_word", rd_word, exp_q.pop_front());
      check("word_valid", {63'h0, valid}, 64'h1);
    end
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    logic [31:0] v;
    stim = 32'h0;
    capture = 1'b0;
    sys_rst = 1'b1;
    core_clk = 1'b0;
    repeat (4) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    check("reset word", word, 64'h0);
    check("reset valid", {63'h0, valid}, 64'h0);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      v = $random(seed);
      v[3:0] = i[3:0];
      v[7:4] = 4'(i % 3);
      cap(v, 1'b1);
    end
    $display("test codes done");
    cap(32'h007FFFFF, 1'b1);
    cap(32'h003B7F7F, 1'b1);
    $display("test flags done");
    repeat (60) begin
      v = $random(seed);
      cap(v, v[31]);
    end
    repeat (3) cap(32'h0, 1'b0);
    check("queue left", 64'(exp_q.size()), 64'h0);
    $display("test random done");
    sys_rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    check("mid reset word", word, 64'h0);
    check("mid reset valid", {63'h0, valid}, 64'h0);
    cap(32'h00400005, 1'b1);
    repeat (3) cap(32'h0, 1'b0);
    check("queue after reset", 64'(exp_q.size()), 64'h0);
    $display("test mid reset done");
    print_verdict();
  end
endmodule : rf_check_word_tb
